// File: design/twt_consts.vh
// Constants of the two-wire target control core: offsets, fields, reset values
`ifndef TWT_CONSTS_VH
`define TWT_CONSTS_VH

// ==========================================================================
// Register offsets (byte addresses on the plain register port)
`define TWT_OFS_TASKS   8'h00
`define TWT_OFS_ENABLE  8'h04
`define TWT_OFS_ADDRESS 8'h08
`define TWT_OFS_TXDATA  8'h0C
`define TWT_OFS_RXDATA  8'h10
`define TWT_OFS_STATUS  8'h14

// ==========================================================================
// Task register bit positions (write one to trigger)
`define TWT_TASK_ARM_TX   0
`define TWT_TASK_ARM_RX   1
`define TWT_TASK_HALT     2
`define TWT_TASK_UNARM_TX 3
`define TWT_TASK_UNARM_RX 4

// ==========================================================================
// Field positions
`define TWT_EN_BIT        0
`define TWT_ST_RXVAL_BIT  4
`define TWT_ST_NACK_BIT   5
`define TWT_ST_LOWPWR_BIT 6

// ==========================================================================
// Reset values
`define TWT_EN_RST    1'b0
`define TWT_ADDR_RST  7'h00
`define TWT_TXD_RST   8'h00
`define TWT_RDATA_RST 32'h0000_0000

`endif

// File: design/twt_pair_buf.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps

module twt_pair_buf #(
  parameter W = 8
) (
  input  wire         mclk,
  input  wire         srst,
  input  wire         ce,
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output wire         in_ready,
  output wire         out_valid,
  output wire [W-1:0] out_data,
  input  wire         out_ready
);

  reg [W-1:0] slot0_q;
  reg [W-1:0] slot1_q;
  reg [1:0]   cnt_q;

  // Head of the queue always sits in slot0, so the reader needs no mux
  wire push = in_valid & (cnt_q != 2'd2);
  wire pop  = out_ready & (cnt_q != 2'd0);

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = slot0_q;

  // ==========================================================================
  // Storage and occupancy
  always @(posedge mclk) begin
    if (srst) begin
      slot0_q <= {W{1'b0}};
      slot1_q <= {W{1'b0}};
      cnt_q   <= 2'd0;
    end else if (ce) begin
      case ({push, pop})
        2'b10: begin
          if (cnt_q == 2'd0) begin
            slot0_q <= in_data;
          end else begin
            slot1_q <= in_data;
          end
          cnt_q <= cnt_q + 2'd1;
        end
        2'b01: begin
          slot0_q <= slot1_q;
          cnt_q   <= cnt_q - 2'd1;
        end
        2'b11: begin
          // Count unchanged; a full buffer cannot push, so cnt_q is 1 here
          slot0_q <= in_data;
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

endmodule // twt_pair_buf

// File: design/twt_target_ctrl.v
// Two-wire target control core: line sampling, target state machine, registers
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "twt_consts.vh"

// ==========================================================================
// Contract
// - Work with controller at 100 or 400 kHz
// - Arm-transmit task sets hidden transmit flag
// - Arm-receive task sets hidden receive flag
// - Unarm transmit clears flag until rearmed
// - Unarm receive clears flag until rearmed
// - Detect restart and stop as transitions
// - Tolerate controller holding clock low
// - Stay low power while not addressed; low_power is set only in ST_IDLE, so it drops during every address byte
// - Leave disabled only after software enables
// - Read enters transmit if armed, else stretch
// - Transmit entry raises event, clears armed flag
// - Restart during transmit returns to idle
// - Stop raises halted, clears flag, idles

module twt_target_ctrl (
  input  wire        mclk,
  input  wire        srst,
  input  wire        ce,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        scl_i,
  output reg         scl_o,
  output reg         scl_oe,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe,
  output reg         transmit_began_event,
  output reg         receive_began_event,
  output reg         halted_event,
  output reg         low_power
);

  localparam ST_DIS  = 3'd0;
  localparam ST_IDLE = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_WTX  = 3'd3;
  localparam ST_WRX  = 3'd4;
  localparam ST_TX   = 3'd5;
  localparam ST_RX   = 3'd6;

  // ==========================================================================
  // Line synchronisers and edge detection
  reg [1:0] scl_sy_q;
  reg [1:0] sda_sy_q;
  reg       scl_p_q;
  reg       sda_p_q;

  // Even at 400 kHz a clock half-period spans hundreds of mclk cycles, so the
  // two-stage delay costs no timing margin
  always @(posedge mclk) begin
    if (srst) begin
      scl_sy_q <= 2'b11;
      sda_sy_q <= 2'b11;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
    end else if (ce) begin
      scl_sy_q <= {scl_sy_q[0], scl_i};
      sda_sy_q <= {sda_sy_q[0], sda_i};
      scl_p_q  <= scl_sy_q[1];
      sda_p_q  <= sda_sy_q[1];
    end
  end

  wire scl_s    = scl_sy_q[1];
  wire sda_s    = sda_sy_q[1];
  // Data moving while the clock stays high marks start or stop
  wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  // Only edges advance the engine; a long low clock simply waits
  wire scl_rise  = scl_s & ~scl_p_q;
  wire scl_fall  = ~scl_s & scl_p_q;

  // ==========================================================================
  // Register decode
  wire wr_tasks  = reg_wr & (reg_addr == `TWT_OFS_TASKS);
  wire arm_tx    = wr_tasks & reg_wdata[`TWT_TASK_ARM_TX];
  wire arm_rx    = wr_tasks & reg_wdata[`TWT_TASK_ARM_RX];
  wire halt_task = wr_tasks & reg_wdata[`TWT_TASK_HALT];
  wire unarm_tx  = wr_tasks & reg_wdata[`TWT_TASK_UNARM_TX];
  wire unarm_rx  = wr_tasks & reg_wdata[`TWT_TASK_UNARM_RX];
  wire rd_rxdata = reg_rd & (reg_addr == `TWT_OFS_RXDATA);

  reg       enable_q;
  reg [6:0] own_addr_q;
  reg [7:0] txdata_q;

  // Software-written configuration
  always @(posedge mclk) begin
    if (srst) begin
      enable_q   <= `TWT_EN_RST;
      own_addr_q <= `TWT_ADDR_RST;
      txdata_q   <= `TWT_TXD_RST;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        `TWT_OFS_ENABLE:  enable_q   <= reg_wdata[`TWT_EN_BIT];
        `TWT_OFS_ADDRESS: own_addr_q <= reg_wdata[6:0];
        `TWT_OFS_TXDATA:  txdata_q   <= reg_wdata[7:0];
        default:          enable_q   <= enable_q;
      endcase
    end
  end

  // ==========================================================================
  // Target state machine
  reg [2:0] state_q;
  reg [7:0] sh_q;
  reg [3:0] cnt_q;
  reg       ackph_q;
  reg       rw_q;
  reg       nack_q;
  reg       restart_q;
  reg       tx_armed_q;
  reg       rx_armed_q;

  wire       buf_in_ready;
  wire       buf_out_valid;
  wire [7:0] buf_out_data;

  // Received byte waits here with the clock held low until the buffer has room
  wire rx_full = (state_q == ST_RX) & (cnt_q == 4'd8) & ~ackph_q & ~scl_s;
  wire rx_push = rx_full & buf_in_ready;
  wire ours    = (state_q == ST_WTX) | (state_q == ST_WRX) | (state_q == ST_TX) | (state_q == ST_RX);

  always @(posedge mclk) begin
    if (srst) begin
      state_q              <= ST_DIS;
      sh_q                 <= 8'h00;
      cnt_q                <= 4'd0;
      ackph_q              <= 1'b0;
      rw_q                 <= 1'b0;
      nack_q               <= 1'b0;
      restart_q            <= 1'b0;
      tx_armed_q           <= 1'b0;
      rx_armed_q           <= 1'b0;
      scl_o                <= 1'b0;
      scl_oe               <= 1'b0;
      sda_o                <= 1'b0;
      sda_oe               <= 1'b0;
      transmit_began_event <= 1'b0;
      receive_began_event  <= 1'b0;
      halted_event         <= 1'b0;
      low_power            <= 1'b0;
    end else if (ce) begin
      transmit_began_event <= 1'b0;
      receive_began_event  <= 1'b0;
      halted_event         <= 1'b0;
      low_power            <= (state_q == ST_IDLE);
      if (unarm_tx) begin
        tx_armed_q <= 1'b0;
      end
      if (unarm_rx) begin
        rx_armed_q <= 1'b0;
      end
      if (!enable_q) begin
        state_q <= ST_DIS;
        scl_oe  <= 1'b0;
        sda_oe  <= 1'b0;
      end else if (halt_task && state_q != ST_DIS) begin
        state_q      <= ST_IDLE;
        halted_event <= 1'b1;
        tx_armed_q   <= 1'b0;
        rx_armed_q   <= 1'b0;
        scl_oe       <= 1'b0;
        sda_oe       <= 1'b0;
        restart_q    <= 1'b0;
      end else if (stop_det && state_q != ST_DIS) begin
        // Stop ends our transfer; a stop meant for another target is silent
        state_q <= ST_IDLE;
        scl_oe  <= 1'b0;
        sda_oe  <= 1'b0;
        restart_q <= 1'b0;
        if (ours) begin
          halted_event <= 1'b1;
          tx_armed_q   <= 1'b0;
          rx_armed_q   <= 1'b0;
        end
      end else if (start_det && state_q != ST_DIS) begin
        scl_oe  <= 1'b0;
        sda_oe  <= 1'b0;
        cnt_q   <= 4'd0;
        ackph_q <= 1'b0;
        if (state_q == ST_TX || state_q == ST_RX) begin
          // Restart drops back to idle; idle then takes the new address
          state_q   <= ST_IDLE;
          restart_q <= 1'b1;
        end else begin
          state_q <= ST_ADDR;
        end
      end else begin
        case (state_q)
          ST_DIS: begin
            if (enable_q) begin
              state_q <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            // Nothing toggles here until a start or a pending restart
            if (restart_q) begin
              restart_q <= 1'b0;
              state_q   <= ST_ADDR;
            end
          end
          ST_ADDR: begin
            if (scl_rise && !ackph_q) begin
              sh_q  <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'd1;
            end else if (cnt_q == 4'd8 && !ackph_q && !scl_s) begin
              if (sh_q[7:1] == own_addr_q) begin
                sda_oe  <= 1'b1;
                ackph_q <= 1'b1;
                rw_q    <= sh_q[0];
              end else begin
                state_q <= ST_IDLE;
              end
            end else if (scl_fall && ackph_q) begin
              sda_oe  <= 1'b0;
              ackph_q <= 1'b0;
              cnt_q   <= 4'd0;
              nack_q  <= 1'b0;
              if (rw_q) begin
                if (tx_armed_q) begin
                  state_q              <= ST_TX;
                  transmit_began_event <= 1'b1;
                  tx_armed_q           <= 1'b0;
                  sh_q                 <= txdata_q;
                  sda_oe               <= ~txdata_q[7];
                end else begin
                  state_q <= ST_WTX;
                  scl_oe  <= 1'b1;
                end
              end else begin
                if (rx_armed_q) begin
                  state_q             <= ST_RX;
                  receive_began_event <= 1'b1;
                  rx_armed_q          <= 1'b0;
                end else begin
                  state_q <= ST_WRX;
                  scl_oe  <= 1'b1;
                end
              end
            end
          end
          ST_WTX: begin
            // Clock stays held low until software arms transmit
            if (tx_armed_q) begin
              state_q              <= ST_TX;
              transmit_began_event <= 1'b1;
              tx_armed_q           <= 1'b0;
              sh_q                 <= txdata_q;
              sda_oe               <= ~txdata_q[7];
              scl_oe               <= 1'b0;
            end
          end
          ST_WRX: begin
            if (rx_armed_q) begin
              state_q             <= ST_RX;
              receive_began_event <= 1'b1;
              rx_armed_q          <= 1'b0;
              scl_oe              <= 1'b0;
            end
          end
          ST_TX: begin
            if (scl_fall && !ackph_q && !nack_q) begin
              if (cnt_q == 4'd7) begin
                sda_oe  <= 1'b0;
                ackph_q <= 1'b1;
              end else begin
                sh_q   <= {sh_q[6:0], 1'b0};
                sda_oe <= ~sh_q[6];
                cnt_q  <= cnt_q + 4'd1;
              end
            end else if (scl_rise && ackph_q) begin
              nack_q <= sda_s;
            end else if (scl_fall && ackph_q) begin
              // After a NACK the line stays released until stop or restart
              ackph_q <= 1'b0;
              cnt_q   <= 4'd0;
              if (!nack_q) begin
                sh_q   <= txdata_q;
                sda_oe <= ~txdata_q[7];
              end
            end
          end
          ST_RX: begin
            if (scl_rise && !ackph_q) begin
              sh_q  <= {sh_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'd1;
            end else if (rx_full) begin
              // Full buffer stretches the clock rather than dropping a byte
              scl_oe <= ~buf_in_ready;
              if (buf_in_ready) begin
                sda_oe  <= 1'b1;
                ackph_q <= 1'b1;
              end
            end else if (scl_fall && ackph_q) begin
              sda_oe  <= 1'b0;
              ackph_q <= 1'b0;
              cnt_q   <= 4'd0;
            end
          end
          default: begin
            state_q <= ST_DIS;
          end
        endcase
      end
      // Set wins over any clear in the same cycle
      if (arm_tx) begin
        tx_armed_q <= 1'b1;
      end
      if (arm_rx) begin
        rx_armed_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Receive buffer between the line engine and software
  twt_pair_buf #(
    .W (8)
  ) u_rx_buf (
    .mclk      (mclk),
    .srst      (srst),
    .ce        (ce),
    .in_valid  (rx_push),
    .in_data   (sh_q),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (rd_rxdata)
  );

  // ==========================================================================
  // Read data, one cycle after the strobe; armed flags are never readable
  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= `TWT_RDATA_RST;
    end else if (ce) begin
      reg_rdata <= `TWT_RDATA_RST;
      if (reg_rd) begin
        case (reg_addr)
          `TWT_OFS_ENABLE:  reg_rdata <= {31'h0000_0000, enable_q};
          `TWT_OFS_ADDRESS: reg_rdata <= {25'h000_0000, own_addr_q};
          `TWT_OFS_TXDATA:  reg_rdata <= {24'h00_0000, txdata_q};
          `TWT_OFS_RXDATA:  reg_rdata <= {24'h00_0000, buf_out_data};
          `TWT_OFS_STATUS:  reg_rdata <= {25'h000_0000, low_power, nack_q, buf_out_valid, 1'b0, state_q};
          default:          reg_rdata <= `TWT_RDATA_RST;
        endcase
      end
    end
  end

endmodule // twt_target_ctrl

// File: bench/twt_target_ctrl_properties.sv
// Concurrent checks on the ports of the two-wire target control core
`timescale 1ns/1ps
`include "twt_consts.vh"

// ==========================================================================
// Checker
module twt_ctrl_props (
  input wire        mclk,
  input wire        srst,
  input wire        ce,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        scl_oe,
  input wire        sda_oe,
  input wire        transmit_began_event,
  input wire        receive_began_event,
  input wire        halted_event,
  input wire        low_power
);
  reg en_q;

  // Shadow of the enable bit, which the ports only show through the bus
  always @(posedge mclk) begin
    if (srst) begin
      en_q <= 1'b0;
    end else if (ce && reg_wr && reg_addr == `TWT_OFS_ENABLE) begin
      en_q <= reg_wdata[0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Task writes, split by what they ask for
  sequence task_wr; ce && reg_wr && reg_addr == `TWT_OFS_TASKS; endsequence
  sequence arm_both; task_wr ##0 reg_wdata[1:0] == 2'b11; endsequence
  // Enabled for two cycles, so the target has surely left the disabled state
  sequence halt_req; task_wr ##0 (reg_wdata[`TWT_TASK_HALT] && en_q && $past(en_q)); endsequence
  sequence off3; !en_q [*3]; endsequence

  chk_tx_pulse: assert property (transmit_began_event |=> !transmit_began_event)
    else $error("transmit start event longer than one cycle");
  chk_rx_pulse: assert property (receive_began_event |=> !receive_began_event)
    else $error("receive start event longer than one cycle");
  chk_halt_pulse: assert property (halted_event |=> !halted_event)
    else $error("halted event longer than one cycle");
  chk_start_awake: assert property (transmit_began_event || receive_began_event |-> !low_power)
    else $error("low power flagged while a transfer starts");
  chk_arm_release: assert property (scl_oe ##0 arm_both |-> ##[1:3] !scl_oe)
    else $error("clock still stretched after arming");
  chk_halt_event: assert property (halt_req |-> ##[1:2] halted_event)
    else $error("halt task gave no halted event");
  chk_halt_free: assert property (halt_req |-> ##3 (!scl_oe && !sda_oe))
    else $error("lines still driven after halt task");
  chk_off_quiet: assert property (off3 |-> !scl_oe && !sda_oe && !low_power && !halted_event)
    else $error("disabled target is active");
  chk_wake_idle: assert property ($rose(en_q) |-> ##[1:3] low_power)
    else $error("enabled target not in low power");
  chk_unmapped_rd: assert property (ce && reg_rd && reg_addr == 8'h18 |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");
endmodule // twt_ctrl_props

bind twt_target_ctrl twt_ctrl_props u_props (
  .mclk(mclk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .transmit_began_event(transmit_began_event), .receive_began_event(receive_began_event),
  .halted_event(halted_event), .low_power(low_power)
);

// File: bench/twt_ctl_model.sv
// Bus controller model that drives clock and data of the two-wire link
`timescale 1ns/1ps

// ==========================================================================
// Controller model
module twt_ctl_model (
  input  wire scl_ln,
  input  wire sda_ln,
  output reg  scl_m,
  output reg  sda_m
);
  integer hold;
  integer w;

  // Both lines rest high; this is the only controller on the bus
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    hold = 0;
  end

  // Release the clock, bounded wait while the target stretches it
  task rise;
    begin
      scl_m = 1'b1;
      w = 0;
      while (scl_ln !== 1'b1 && w < 5000) begin
        #4;
        w = w + 1;
      end
    end
  endtask

  // One bit at a 64 ns period; hold keeps the clock low longer
  task bit_io(input b, output r);
    begin
      sda_m = b;
      #16;
      rise;
      #16;
      r = sda_ln;
      #16;
      scl_m = 1'b0;
      #(16 + hold);
    end
  endtask

  // Start, or restart when issued inside a frame
  task start;
    begin
      sda_m = 1'b1;
      #16;
      rise;
      #16;
      sda_m = 1'b0;
      #16;
      scl_m = 1'b0;
      #16;
    end
  endtask

  // Stop: data rises while the clock is high
  task stop;
    begin
      sda_m = 1'b0;
      #16;
      rise;
      #16;
      sda_m = 1'b1;
      #16;
    end
  endtask

  // Byte MSB first, then the ninth bit; nk is our own acknowledge level
  task xfer(input [7:0] d, input nk, output [7:0] q, output ak);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(d[i], r);
        q[i] = r;
      end
      bit_io(nk, ak);
    end
  endtask
endmodule // twt_ctl_model

// File: bench/testbench.sv
// Self-checking bench for the two-wire target control core
`timescale 1ns/1ps
`include "twt_consts.vh"

// ==========================================================================
// Bench top
module testbench;
  reg         mclk;
  reg         srst;
  reg         ce;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  wire [31:0] reg_rdata;
  wire        scl_o;
  wire        scl_oe;
  wire        sda_o;
  wire        sda_oe;
  wire        transmit_began_event;
  wire        receive_began_event;
  wire        halted_event;
  wire        low_power;
  wire        scl_m;
  wire        sda_m;
  wire        scl_ln = (scl_oe ? scl_o : 1'b1) & scl_m;
  wire        sda_ln = (sda_oe ? sda_o : 1'b1) & sda_m;
  integer     err_total;
  integer     checked;
  integer     tx_n;
  integer     rx_n;
  integer     halt_n;
  integer     i;
  reg  [7:0]  q;
  reg         ak;

  twt_target_ctrl DUT (
    .mclk(mclk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_ln), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_ln), .sda_o(sda_o), .sda_oe(sda_oe),
    .transmit_began_event(transmit_began_event), .receive_began_event(receive_began_event),
    .halted_event(halted_event), .low_power(low_power)
  );

  twt_ctl_model m (.scl_ln(scl_ln), .sda_ln(sda_ln), .scl_m(scl_m), .sda_m(sda_m));

  // 250 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Event pulses are counted, since they last one cycle only
  always @(posedge mclk) begin
    tx_n <= tx_n + (transmit_began_event === 1'b1);
    rx_n <= rx_n + (receive_began_event === 1'b1);
    halt_n <= halt_n + (halted_event === 1'b1);
  end

  // ==========================================================================
  // Tasks
  task cmp(input string nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("unexpected %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task rd(input [7:0] a, input [31:0] e, input string nm);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      cmp(nm, e, reg_rdata);
    end
  endtask

  task call(input [7:0] a);
    begin
      m.start;
      m.xfer(a, 1'b1, q, ak);
    end
  endtask

  // Byte attempt that the target must stall, freed by a task write
  task stall(input [31:0] t, input string nm);
    begin
      fork
        m.xfer(8'hFF, 1'b1, q, ak);
        begin
          repeat (150) @(posedge mclk);
          #1;
          cmp(nm, 1, scl_oe);
          wr(`TWT_OFS_TASKS, t);
        end
      join
    end
  endtask

  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  // ==========================================================================
  // Watchdog, well beyond the expected run of some 15 us
  initial begin
    #200000;
    err_total = err_total + 1;
    conclude;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    err_total = 0;
    checked = 0;
    tx_n = 0;
    rx_n = 0;
    halt_n = 0;
    srst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rd(`TWT_OFS_STATUS, 32'h0000_0000, "status");
    rd(`TWT_OFS_ENABLE, 32'h0000_0000, "enable");
    wr(`TWT_OFS_ADDRESS, 32'h0000_002A);
    rd(`TWT_OFS_ADDRESS, 32'h0000_002A, "address");
    wr(`TWT_OFS_TXDATA, 32'h0000_005C);
    rd(8'h18, 32'h0000_0000, "unmapped");
    call(8'h54);
    m.stop;
    cmp("ack while off", 1, ak);
    wr(`TWT_OFS_ENABLE, 32'h0000_0001);
    repeat (4) @(posedge mclk);
    #1;
    cmp("low power", 1, low_power);
    call(8'h56);
    m.stop;
    cmp("ack other address", 1, ak);
    cmp("still low power", 1, low_power);
    wr(`TWT_OFS_TASKS, 32'h0000_0002);
    call(8'h54);
    cmp("ack write", 0, ak);
    m.xfer(8'hA5, 1'b1, q, ak);
    m.stop;
    cmp("rx events", 1, rx_n);
    cmp("halted events", 1, halt_n);
    rd(`TWT_OFS_STATUS, 32'h0000_0051, "status rx");
    rd(`TWT_OFS_RXDATA, 32'h0000_00A5, "rx byte");
    // Three bytes with no read: the third waits on a full buffer, none is lost
    wr(`TWT_OFS_TASKS, 32'h0000_0002);
    call(8'h54);
    m.xfer(8'h11, 1'b1, q, ak);
    m.xfer(8'h22, 1'b1, q, ak);
    fork
      m.xfer(8'h33, 1'b1, q, ak);
      begin
        repeat (150) @(posedge mclk);
        #1;
        cmp("rx full stretch", 1, scl_oe);
        rd(`TWT_OFS_RXDATA, 32'h0000_0011, "rx first");
      end
    join
    cmp("ack after room", 0, ak);
    m.stop;
    rd(`TWT_OFS_RXDATA, 32'h0000_0022, "rx second");
    rd(`TWT_OFS_RXDATA, 32'h0000_0033, "rx third");
    m.hold = 100;
    call(8'h55);
    stall(32'h0000_0003, "stretch read");
    cmp("tx byte", 32'h0000_005C, q);
    cmp("tx events", 1, tx_n);
    rd(`TWT_OFS_STATUS, 32'h0000_0025, "status tx");
    m.hold = 0;
    call(8'h54);
    // Arm transmit mid-frame; the stop must spend it again
    wr(`TWT_OFS_TASKS, 32'h0000_0001);
    m.stop;
    cmp("rx after restart", 3, rx_n);
    cmp("halted after stop", 3, halt_n);
    call(8'h55);
    stall(32'h0000_0004, "tx flag spent");
    m.stop;
    cmp("halt task", 4, halt_n);
    // Arm then unarm each direction; the command must then stall
    for (i = 0; i < 2; i = i + 1) begin
      wr(`TWT_OFS_TASKS, 32'h0000_0001 << i);
      wr(`TWT_OFS_TASKS, 32'h0000_0008 << i);
      call({7'h2A, ~i[0]});
      stall(32'h0000_0004, "unarmed");
      m.stop;
    end
    cmp("tx after unarm", 1, tx_n);
    cmp("rx after unarm", 3, rx_n);
    cmp("halts", 6, halt_n);
    // A write while the clock enable is low must leave the target enabled
    @(posedge mclk);
    ce <= 1'b0;
    wr(`TWT_OFS_ENABLE, 32'h0000_0000);
    ce <= 1'b1;
    rd(`TWT_OFS_ENABLE, 32'h0000_0001, "frozen write");
    wr(`TWT_OFS_ENABLE, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    rd(`TWT_OFS_STATUS, 32'h0000_0000, "disabled");
    conclude;
  end
endmodule // testbench
